// ### common/pcc_pkg.sv
// pin cycle counter package: timing constants, variant selection, command and result carriers
// assumes a 10 MHz system clock; pins are sampled synchronously
package pcc_pkg;

  localparam int PCC_CLK_HZ = 10000000;
  localparam int PCC_PIN_COUNT = 16;
  localparam int PCC_SEL_W = 4;
  localparam int PCC_CNT_W = 16;

  // window time unit per variant, in nanoseconds
  localparam int PCC_UNIT_1MS_NS = 1000000;
  localparam int PCC_UNIT_400US_NS = 400000;
  localparam int PCC_UNIT_287US_NS = 287000;
  localparam int PCC_UNIT_720US_NS = 720000;

  // minimum pulse width of the 1 ms variant, in nanoseconds
  localparam int PCC_MIN_PULSE_NS = 4160;
  localparam int PCC_MAX_FREQ_HZ = 120000;
  localparam int PCC_CLK_PERIOD_NS = 1000000000 / PCC_CLK_HZ;

  typedef enum logic [1:0] {
    PCC_VAR_1MS = 2'h0,
    PCC_VAR_400US = 2'h1,
    PCC_VAR_287US = 2'h2,
    PCC_VAR_720US = 2'h3
  } pcc_variant_t;

  // cycles per time unit, rounded down (a window length is a longest time)
  function automatic int pcc_unit_cycles(input pcc_variant_t v);
    int ns;
    ns = PCC_UNIT_1MS_NS;
    case (v)
      PCC_VAR_400US: ns = PCC_UNIT_400US_NS;
      PCC_VAR_287US: ns = PCC_UNIT_287US_NS;
      PCC_VAR_720US: ns = PCC_UNIT_720US_NS;
      default: ns = PCC_UNIT_1MS_NS;
    endcase
    pcc_unit_cycles = (ns / PCC_CLK_PERIOD_NS >= 1) ? ns / PCC_CLK_PERIOD_NS : 1;
  endfunction

  typedef struct packed {
    logic [PCC_SEL_W-1:0] pin;
    logic [PCC_CNT_W-1:0] duration;
  } pcc_cmd_t;

  typedef struct packed {
    logic done;
    logic [PCC_CNT_W-1:0] total;
  } pcc_result_t;

  typedef enum logic [2:0] {
    PCC_IDLE = 3'b001,
    PCC_ARM = 3'b010,
    PCC_COUNT = 3'b100
  } pcc_state_t;

endpackage

// ### core/pcc_counter.sv
// pin cycle counter: counts full cycles on one selected pin over a timed window
// assumes pins synchronous to sys_clk and that the issuer holds start for one cycle
//
// Behaviour
// RULE_01 - a pin select of 0 to 15 is taken and that pin is made an input before the window opens.
// RULE_02 - a window length of 1 to 65535 is taken and counting lasts that many time units.
// RULE_03 - the time unit is a per-variant constant of 1 ms, 400 us, 287 us or 720 us.
// RULE_04 - the count rises once per full cycle of two opposite transitions, not per edge.
// RULE_05 - when the window ends the accumulated total is delivered as the result.
// RULE_06 - counter and result are 16 bits wide.
// RULE_07 - the source keeps each high and low phase at least the minimum pulse width.
// RULE_08 - square waves up to the variant's maximum frequency are counted reliably.
// RULE_09 - the counter clears at each window start, stops at its end, and the result holds until the next start.
`timescale 1ns/1ns
module pcc_counter #(
  parameter pcc_pkg::pcc_variant_t VARIANT = pcc_pkg::PCC_VAR_1MS,
  parameter int UNIT_CYCLES = pcc_pkg::pcc_unit_cycles(VARIANT)
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire pcc_pkg::pcc_cmd_t cmd,
  input wire logic [pcc_pkg::PCC_PIN_COUNT-1:0] pin_in,
  output logic [pcc_pkg::PCC_PIN_COUNT-1:0] pin_oe_n,
  output logic busy,
  output pcc_pkg::pcc_result_t result
);
  import pcc_pkg::*;

  localparam int UNIT_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);

  pcc_state_t state, next_state;
  logic [PCC_SEL_W-1:0] sel, next_sel;
  logic [PCC_CNT_W-1:0] units_left, next_units_left;
  logic [UNIT_W-1:0] tick, next_tick;
  // RULE_06 word-wide count
  logic [PCC_CNT_W-1:0] count, next_count;
  logic first_lvl, next_first_lvl;
  logic last_lvl, next_last_lvl;
  logic half, next_half;
  logic [PCC_PIN_COUNT-1:0] next_pin_oe_n;
  logic next_busy;
  pcc_result_t next_result;
  logic pin_now;
  logic pin_edge;

  // wraps at the word width, like the result it feeds
  function automatic logic [PCC_CNT_W-1:0] pcc_bump(input logic [PCC_CNT_W-1:0] v);
    pcc_bump = v + PCC_CNT_W'(1);
  endfunction

  assign pin_now = pin_in[sel];
  // RULE_08 edge seen every clock
  // one sample per clock resolves phases far shorter than the minimum pulse width
  assign pin_edge = (pin_now != last_lvl);

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_units_left = units_left;
    next_tick = tick;
    next_count = count;
    next_first_lvl = first_lvl;
    next_last_lvl = last_lvl;
    next_half = half;
    next_pin_oe_n = pin_oe_n;
    next_busy = busy;
    next_result = result;
    next_result.done = 1'b0;
    case (state)
      PCC_IDLE: begin
        // a zero length is treated as one unit, the shortest legal window
        if (start) begin
          // RULE_01 take pin, force input
          next_sel = cmd.pin;
          next_pin_oe_n = '1;
          // RULE_02 load window length
          next_units_left = (cmd.duration == '0) ? PCC_CNT_W'(1) : cmd.duration;
          next_busy = 1'b1;
          next_state = PCC_ARM;
        end
      end
      PCC_ARM: begin
        // RULE_09 clear at window start
        next_count = '0;
        next_tick = '0;
        next_half = 1'b0;
        next_first_lvl = pin_now;
        next_last_lvl = pin_now;
        next_state = PCC_COUNT;
      end
      PCC_COUNT: begin
        // RULE_04 two transitions make one cycle
        if (pin_edge) begin
          next_last_lvl = pin_now;
          next_half = ~half;
          if (half) begin
            next_count = pcc_bump(count);
          end
        end
        // RULE_03 per-variant unit timing
        if (tick == UNIT_LAST) begin
          next_tick = '0;
          next_units_left = units_left - PCC_CNT_W'(1);
          if (units_left == PCC_CNT_W'(1)) begin
            // RULE_05 deliver total
            next_result.total = (pin_edge && half) ? pcc_bump(count) : count;
            next_result.done = 1'b1;
            next_busy = 1'b0;
            next_state = PCC_IDLE;
          end
        end else begin
          next_tick = tick + UNIT_W'(1);
        end
      end
      default: begin
        next_state = PCC_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PCC_IDLE;
      sel <= '0;
      units_left <= '0;
      tick <= '0;
      count <= '0;
      first_lvl <= 1'b0;
      last_lvl <= 1'b0;
      half <= 1'b0;
      pin_oe_n <= '1;
      busy <= 1'b0;
      result <= '0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      units_left <= next_units_left;
      tick <= next_tick;
      count <= next_count;
      first_lvl <= next_first_lvl;
      last_lvl <= next_last_lvl;
      half <= next_half;
      pin_oe_n <= next_pin_oe_n;
      busy <= next_busy;
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertion helpers: cycles spent counting and the units that were asked for
  int window_len, next_window_len;
  logic [PCC_CNT_W-1:0] win_units, next_win_units;

  always_comb begin
    next_window_len = window_len;
    next_win_units = win_units;
    if (state == PCC_IDLE && start) begin
      next_window_len = 0;
      next_win_units = (cmd.duration == '0) ? PCC_CNT_W'(1) : cmd.duration;
    end else if (state == PCC_COUNT) begin
      next_window_len = window_len + 1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      window_len <= 0;
      win_units <= '0;
    end else begin
      window_len <= next_window_len;
      win_units <= next_win_units;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  pin_input_a: assert property (state != PCC_IDLE |-> pin_oe_n == '1) // RULE_01
    else $error("pin not input during measurement");
  start_arm_a: assert property (state == PCC_IDLE && start |=> state == PCC_ARM && busy) // RULE_02
    else $error("start not taken");
  // window timing
  window_len_a: assert property (result.done |-> window_len == int'(win_units) * UNIT_CYCLES) // RULE_03
    else $error("window not whole units");
  window_end_a: assert property (state == PCC_COUNT && units_left == PCC_CNT_W'(1) && tick == UNIT_LAST // RULE_02
    |=> result.done && !busy)
    else $error("window did not end after its last unit");
  units_left_a: assert property (state != PCC_IDLE |-> units_left != '0) // RULE_02
    else $error("window length ran out while measuring");

  // cycle pairing
  cycle_pair_a: assert property (state == PCC_COUNT && pin_now != last_lvl && !half |=> count == $past(count)) // RULE_04
    else $error("count moved on a single edge");
  cycle_inc_a: assert property (state == PCC_COUNT && pin_now != last_lvl && half && tick != UNIT_LAST // RULE_08
    |=> count == $past(count) + 16'h0001)
    else $error("full cycle missed");
  level_pair_a: assert property (state == PCC_COUNT && !half |-> last_lvl == first_lvl) // RULE_04
    else $error("half-cycle flag out of step with pin level");

  // result delivery and hand-back
  done_pulse_a: assert property (result.done |-> !busy && state == PCC_IDLE ##1 !result.done) // RULE_05
    else $error("done not single pulse");
  busy_level_a: assert property (busy == (state != PCC_IDLE)) // RULE_05
    else $error("busy out of step with measurement");
  refuse_start_a: assert property (busy && start |=> $stable(sel)) // RULE_01
    else $error("pin select changed while busy");
  clear_start_a: assert property (state == PCC_ARM |=> count == '0 && !half) // RULE_09
    else $error("counter not cleared at window start");
  result_hold_a: assert property (!result.done && state != PCC_COUNT |=> $stable(result.total)) // RULE_09
    else $error("result changed outside window end");

  short_window_c: cover property (state == PCC_IDLE && start && cmd.duration == 16'h0001 ##[2:1000] result.done);
  zero_window_c: cover property (state == PCC_IDLE && start && cmd.duration == 16'h0000 ##[2:1000] result.done);
  counted_c: cover property (result.done && result.total != '0);
  end_edge_c: cover property (state == PCC_COUNT && pin_edge && half && tick == UNIT_LAST
    && units_left == PCC_CNT_W'(1));
  back_to_back_c: cover property (result.done ##1 start);

endmodule // pcc_counter

// ### bench/pcc_pulse_src.sv
// far-side square-wave source on the selected pin; other pins toggle every cycle
// assumes go is a one-cycle pulse driven at the falling edge
`timescale 1ns/1ns
module pcc_pulse_src (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [3:0] sel,
  input wire logic [15:0] half,
  input wire logic [15:0] cycles,
  output logic [15:0] pin_in
);
  logic lvl;
  int left;
  int tick;
  initial begin
    lvl = 1'b0;
    left = 0;
    tick = 0;
    pin_in = 16'h5555;
  end
  always @(negedge sys_clk) begin
    if (go) begin
      left = 2 * cycles;
      tick = half;
    end else if (left > 0) begin
      tick--;
      if (tick == 0) begin
        lvl = ~lvl;
        left--;
        tick = half;
      end
    end
    // unselected pins chatter so a wrong pin choice shows
    pin_in <= (~pin_in & ~(16'h0001 << sel)) | (16'(lvl) << sel);
  end
endmodule // pcc_pulse_src

// ### bench/testbench.sv
// self-checking bench for the pin cycle counter
// assumes a short unit of 10 clocks and one source on the selected pin
`timescale 1ns/1ns
module testbench;
  import pcc_pkg::*;
  localparam int U = 10;
  // shortest legal phase in clocks, rounded up
  localparam int HMIN = PCC_MIN_PULSE_NS / PCC_CLK_PERIOD_NS + 1;
  logic sys_clk, arst_n, start, go, busy;
  pcc_cmd_t cmd;
  pcc_result_t result;
  logic [15:0] pin_in, pin_oe_n, half, cyc;
  logic [31:0] lfsr;
  int err_total, tests_run, ncyc;
  pcc_counter #(.UNIT_CYCLES(U)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .cmd(cmd),
    .pin_in(pin_in), .pin_oe_n(pin_oe_n), .busy(busy), .result(result));
  pcc_pulse_src src_u (.sys_clk(sys_clk), .go(go), .sel(cmd.pin), .half(half), .cycles(cyc), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // zero length runs as one unit
  function automatic logic [31:0] exp_len(input logic [15:0] n);
    return 32'(2 + ((n == 16'h0) ? 1 : n) * U);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(input logic [3:0] p, input logic [15:0] n, input logic [15:0] k, input logic [15:0] h);
    int t;
    @(negedge sys_clk);
    cmd <= '{pin: p, duration: n};
    half <= h;
    cyc <= k;
    start <= 1'b1;
    @(negedge sys_clk);
    start <= 1'b0;
    go <= 1'b1;
    @(negedge sys_clk);
    go <= 1'b0;
    start <= 1'b1; // ignored while busy
    check(32'(busy), 32'h1, "busy after take");
    @(negedge sys_clk);
    start <= 1'b0;
    check(32'(pin_oe_n), 32'h0000FFFF, "pins stay inputs");
    // cycles counted from the one that carried start
    t = 3;
    while (result.done !== 1'b1 && t < 70000) begin
      @(negedge sys_clk);
      t++;
    end
    check(32'(t), exp_len(n), "window length");
    check(32'(result.total), 32'(k), "cycle total");
    repeat (3) @(negedge sys_clk);
    check(32'(result.total), 32'(k), "total held");
    check(32'(busy), 32'h0, "idle after window");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    ncyc++;
    if (ncyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    logic [15:0] k, h;
    arst_n = 1'b0;
    start = 1'b0;
    go = 1'b0;
    cmd = '0;
    half = 16'h002A;
    cyc = 16'h0;
    lfsr = 32'hA3007D81;
    err_total = 0;
    tests_run = 0;
    ncyc = 0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    run(4'h0, 16'h0000, 16'h0000, 16'h002A);
    run(4'hF, 16'h0001, 16'h0000, 16'h002A);
    // fastest legal wave
    run(4'h5, 16'h001B, 16'h0003, 16'h002A);
    // reset in mid-window drops the measurement at once
    @(negedge sys_clk);
    cmd <= '{pin: 4'h3, duration: 16'h0040};
    start <= 1'b1;
    @(negedge sys_clk);
    start <= 1'b0;
    repeat (20) @(negedge sys_clk);
    check(32'(busy), 32'h1, "busy before reset");
    arst_n = 1'b0;
    @(negedge sys_clk);
    check(32'(busy), 32'h0, "busy cleared by reset");
    check(32'(result), 32'h0, "result cleared by reset");
    check(32'(pin_oe_n), 32'h0000FFFF, "pins input in reset");
    arst_n = 1'b1;
    repeat (8) begin
      k = 16'(rnd() % 20);
      h = 16'(HMIN + rnd() % 20);
      run(4'(rnd()), 16'((2 * k * h) / U + 2 + rnd() % 5), k, h);
    end
    stop_test();
  end
endmodule // testbench
